// [hdl/fpc_pkg.sv]
// package for the front-panel run/step control block
// assumes a single 20 MHz clock domain; no software registers
package fpc_pkg;

  localparam int CLK_PERIOD_NS = 50;

  // run/stop condition of the machine
  typedef enum logic [1:0] {
    RUN_STOPPED,
    RUN_RUNNING,
    RUN_STEPPING
  } fpc_mode_t;

  // operator switches, active high once conditioned
  typedef struct packed {
    logic run;
    logic stop;
    logic singleStep;
    logic slow;
    logic protect;
    logic unprotect;
    logic promSwitch;
  } fpc_switches_t;

  localparam int SW_W = $bits(fpc_switches_t);

  localparam fpc_switches_t SW_RESET = '{default: 1'b0};

  // bus strobes and timing inputs from the same system clock logic, plus the asynchronous protect status pin
  typedef struct packed {
    logic psync;
    logic ststb;
    logic phaseStrobe;
    logic slowRatePulse;
    logic powerOnClear;
    logic protectStatusN;
  } fpc_bus_in_t;

endpackage

// [hdl/fpc_front_panel.sv]
// front-panel run, stop, step, slow and protect control
// assumes bus strobes arrive on ref_clk; switches and status pins are asynchronous
`timescale 1ns/10ps

// Behaviour
// [R1] run state holds processor ready high continuously
// [R2] run press asserts front-panel ready low, giving processor ready high
// [R3] stopped: phase strobe gate low; it pulses only on a prom switch
// [R4] each single step gives one ready pulse; step-clear pulse ends it
// [R5] holding slow gates slow-rate pulses into repeated ready pulses
// [R6] step-clear only pulses low, never held low
// [R7] step-clear pulses come from psync and ststb while power-on clear high
// [R8] single step or slow while running forces the stopped condition
// [R9] protect and unprotect switches drive their active-low bus lines while held
// [R10] memory board changes protection only when addressed during protect lines
// [R11] read-only memory board always reports protected when addressed
// [R12] protect indicator lights while the protect status line is low
// [R13] switches are synchronised before affecting ready, clear or protect
module fpc_front_panel (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  clkEn,
  input  wire fpc_pkg::fpc_switches_t switchesRaw,
  input  wire fpc_pkg::fpc_bus_in_t   busIn,
  output logic                       processorReady,
  output logic                       front_panel_ready_n,
  output logic                       stepClearN,
  output logic                       phaseStrobeGated,
  output logic                       protectN,
  output logic                       unprotectN,
  output logic                       protectLed,
  output logic                       waitLed
);

  typedef struct packed {
    fpc_pkg::fpc_switches_t swMeta;
    fpc_pkg::fpc_switches_t swSync;
    fpc_pkg::fpc_switches_t swPrev;
    // two-flop synchroniser for the async protect status pin; bit 1 is the clean copy
    logic [1:0]             psMeta;
    logic                   slowPrev;
    logic                   psyncPrev;
    fpc_pkg::fpc_mode_t     mode;
    logic                   stepArmed;
    logic                   ready;
    logic                   frdyN;
    logic                   clrN;
    logic                   phaseGate;
    logic                   protN;
    logic                   unprotN;
    logic                   led;
    logic                   waitL;
  } fpc_state_t;

  fpc_state_t state_q;
  fpc_state_t state_d;

  fpc_pkg::fpc_switches_t swRise;
  logic                   slowTick;
  logic                   clearEvent;

  always_comb
  begin
    state_d = state_q;
    // two-stage synchronisers; the first stage feeds only the second
    state_d.swMeta    = switchesRaw;                                    // see [R13]
    state_d.swSync    = state_q.swMeta;
    state_d.swPrev    = state_q.swSync;
    state_d.psMeta    = {state_q.psMeta[0], busIn.protectStatusN};           // see [R13]
    state_d.slowPrev  = busIn.slowRatePulse;
    state_d.psyncPrev = busIn.psync;

    swRise     = state_q.swSync & ~state_q.swPrev;
    slowTick   = busIn.slowRatePulse & ~state_q.slowPrev;
    // a clear lasts as long as ststb is high with psync high the cycle before, so it is held low only while those strobes last
    clearEvent = busIn.powerOnClear && busIn.ststb && state_q.psyncPrev; // see [R7]

    state_d.clrN  = ~clearEvent;                                        // see [R6]
    state_d.ready = 1'b0;

    case (state_q.mode)
      fpc_pkg::RUN_RUNNING:
      begin
        state_d.ready = 1'b1;                                           // see [R1]
        if (swRise.singleStep || swRise.slow || state_q.swSync.stop)
        begin
          state_d.mode  = fpc_pkg::RUN_STOPPED;                         // see [R8]
          state_d.ready = 1'b0;
        end
      end
      fpc_pkg::RUN_STEPPING:
      begin
        // one ready pulse per step, held until the step-clear strobe
        state_d.ready = 1'b1;                                           // see [R4]
        if (clearEvent)
        begin
          state_d.mode  = fpc_pkg::RUN_STOPPED;
          state_d.ready = 1'b0;
        end
      end
      fpc_pkg::RUN_STOPPED:
      begin
        if (swRise.run && !state_q.swSync.stop)
        begin
          state_d.mode  = fpc_pkg::RUN_RUNNING;                         // see [R2]
          state_d.ready = 1'b1;
        end
        else if (swRise.singleStep ||
                 (state_q.swSync.slow && slowTick))                     // see [R5]
        begin
          state_d.mode  = fpc_pkg::RUN_STEPPING;                        // see [R4]
          state_d.ready = 1'b1;
        end
      end
      default:
      begin
        state_d.mode = fpc_pkg::RUN_STOPPED;
      end
    endcase

    state_d.frdyN = ~(state_d.mode == fpc_pkg::RUN_RUNNING);            // see [R2]
    // outside the running state, the phase strobe only reaches the gated output while the prom switch is held
    state_d.phaseGate = busIn.phaseStrobe &&
                        (state_d.mode == fpc_pkg::RUN_RUNNING || state_q.swSync.promSwitch); // see [R3]
    state_d.protN   = ~state_q.swSync.protect;                          // see [R9]
    state_d.unprotN = ~state_q.swSync.unprotect;                        // see [R9]
    // only the second synchroniser flop is read, so a metastable first stage never reaches the lamp
    state_d.led     = ~state_q.psMeta[1];                               // see [R12]
    state_d.waitL   = ~state_d.ready;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || !busIn.powerOnClear)
    begin
      state_q       <= '0;
      state_q.mode  <= fpc_pkg::RUN_STOPPED;
      state_q.frdyN <= 1'b1;
      state_q.clrN  <= 1'b1;
      state_q.protN <= 1'b1;
      state_q.unprotN <= 1'b1;
      state_q.psMeta  <= 2'h3;
      state_q.waitL   <= 1'b1;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
    end
  end

  assign processorReady      = state_q.ready;
  assign front_panel_ready_n = state_q.frdyN;
  assign stepClearN          = state_q.clrN;
  assign phaseStrobeGated    = state_q.phaseGate;
  assign protectN            = state_q.protN;
  assign unprotectN          = state_q.unprotN;
  assign protectLed          = state_q.led;
  assign waitLed             = state_q.waitL;

endmodule

// [bench/fpc_front_panel_assertions.sv]
// port checker for fpc_front_panel
// assumes clkEn and powerOnClear stay high
`timescale 1ns/10ps
module fpc_front_panel_assertions (
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic                   clkEn,
  input wire fpc_pkg::fpc_switches_t switchesRaw,
  input wire fpc_pkg::fpc_bus_in_t   busIn,
  input wire logic                   processorReady,
  input wire logic                   front_panel_ready_n,
  input wire logic                   stepClearN,
  input wire logic                   phaseStrobeGated,
  input wire logic                   protectN,
  input wire logic                   unprotectN,
  input wire logic                   protectLed,
  input wire logic                   waitLed
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_run_ready: assert property (!front_panel_ready_n |-> processorReady) else $error("run drops ready");
  chk_run_start: assert property ($rose(switchesRaw.run) && !switchesRaw.stop && front_panel_ready_n
    |-> ##[2:5] !front_panel_ready_n) else $error("run press ignored");
  chk_gate_src: assert property (phaseStrobeGated |-> $past(busIn.phaseStrobe)) else $error("gate without strobe");
  chk_step_end: assert property ($fell(stepClearN) && front_panel_ready_n |-> !processorReady) else $error("step not ended");
  chk_clr_pulse: assert property (!stepClearN |=> stepClearN) else $error("clear held low");
  chk_clr_cause: assert property ($fell(stepClearN) |-> $past(busIn.ststb) && $past(busIn.psync, 2)
    && $past(busIn.powerOnClear)) else $error("clear without strobes");
  chk_stop_force: assert property ($rose(switchesRaw.singleStep) && !front_panel_ready_n
    |-> ##[2:6] front_panel_ready_n) else $error("step kept running");
  chk_prot_lvl: assert property (protectN == !$past(switchesRaw.protect, 3)) else $error("protect line");
  chk_led_lvl: assert property (protectLed == !$past(busIn.protectStatusN, 3)) else $error("protect led");
  chk_wait_led: assert property (waitLed == !processorReady) else $error("wait led");
  cover property ($fell(stepClearN));
  cover property (!protectN);
  cover property ($rose(processorReady) && front_panel_ready_n);
endmodule
bind fpc_front_panel fpc_front_panel_assertions chk_i (.*);

// [bench/fpc_bus_model.sv]
// far side: processor cycle strobes and one memory board
// assumes the board is always addressed
`timescale 1ns/10ps
module fpc_bus_model (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic processorReady,
  input  wire logic protectN,
  input  wire logic unprotectN,
  output logic      psync,
  output logic      ststb,
  output logic      protectStatusN
);
  // a read-only board reports protected whenever addressed
  localparam bit ROM_BOARD = 1'b0;
  // a machine cycle starts only while ready is high
  always_ff @(posedge ref_clk)
  begin
    psync <= !rst && processorReady && !psync && !ststb;
    ststb <= !rst && psync;
    if (rst)
      protectStatusN <= 1'b1;
    else if (ROM_BOARD)
      protectStatusN <= 1'b0;
    else if (!protectN || !unprotectN)
      protectStatusN <= protectN;
  end
endmodule

// [bench/tb_top.sv]
// scenario bench for fpc_front_panel
// assumes clkEn and powerOnClear stay high
`timescale 1ns/10ps
module tb_top;
  logic                   ref_clk = 1'b0;
  logic                   rst = 1'b1;
  fpc_pkg::fpc_switches_t sw = fpc_pkg::SW_RESET;
  logic [3:0]             tick = 4'h0;
  logic                   rdy, frdyN, clrN, gate, protN, unprN, pLed, wLed, psync, ststb, psN;
  int                     err_total = 0, comparisons = 0, cyc = 0, n;
  always #25 ref_clk = ~ref_clk;
  fpc_bus_model BUS (.ref_clk(ref_clk), .rst(rst), .processorReady(rdy), .protectN(protN),
    .unprotectN(unprN), .psync(psync), .ststb(ststb), .protectStatusN(psN));
  fpc_front_panel DUT (.ref_clk(ref_clk), .rst(rst), .clkEn(1'b1), .switchesRaw(sw),
    .busIn({psync, ststb, tick[1], &tick, 1'b1, psN}), .processorReady(rdy), .front_panel_ready_n(frdyN),
    .stepClearN(clrN), .phaseStrobeGated(gate), .protectN(protN), .unprotectN(unprN), .protectLed(pLed),
    .waitLed(wLed));
  task automatic summarize;
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    tick <= tick + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // rising edges of s, sampled once settled after each edge
  task automatic cnt(ref logic s, input int k);
    logic p;
    p = s;
    n = 0;
    repeat (k)
    begin
      @(posedge ref_clk);
      #1;
      n += int'(s & !p);
      p = s;
    end
    @(posedge ref_clk);
  endtask
  task automatic t_run;
    sw.run <= 1'b1;
    w(6);
    sw.run <= 1'b0;
    chk(rdy, 1'b1);
    chk(frdyN, 1'b0);
    chk(wLed, 1'b0);
  endtask
  task automatic t_step;
    sw.singleStep <= 1'b1;
    w(8);
    sw.singleStep <= 1'b0;
    chk(rdy, 1'b0);
    w(4);
    sw.singleStep <= 1'b1;
    cnt(rdy, 24);
    chk(n, 1);
    sw.singleStep <= 1'b0;
    cnt(gate, 24);
    chk(n, 0);
    sw.promSwitch <= 1'b1;
    cnt(gate, 12);
    chk(n > 0, 1'b1);
    sw.promSwitch <= 1'b0;
  endtask
  task automatic t_slow;
    sw.slow <= 1'b1;
    cnt(rdy, 48);
    chk(n > 1, 1'b1);
    sw.slow <= 1'b0;
    w(12);
  endtask
  task automatic t_prot;
    sw.protect <= 1'b1;
    w(10);
    chk({protN, pLed}, 2'h1);
    sw.protect <= 1'b0;
    sw.unprotect <= 1'b1;
    w(10);
    chk({protN, unprN, pLed}, 3'h4);
    sw.unprotect <= 1'b0;
  endtask
  initial
  begin
    w(8);
    rst <= 1'b0;
    w(2);
    t_run;
    t_step;
    t_slow;
    t_prot;
    summarize();
  end
endmodule
